//--- core/mcm_pkg.sv
// Package for the main clock monitor and register write protection block.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package mcm_pkg;
	// Register byte offsets
	localparam logic [7:0] MCM_CTRL_OFS    = 8'h00;
	localparam logic [7:0] MCM_STAT_OFS    = 8'h04;
	localparam logic [7:0] MCM_PROT_OFS    = 8'h08;
	localparam logic [7:0] MCM_IRQ_ST_OFS  = 8'h0C;
	localparam logic [7:0] MCM_IRQ_MSK_OFS = 8'h10;
	localparam logic [7:0] MCM_CLK_REG_OFS = 8'h14;
	localparam logic [7:0] MCM_MODE_REG_OFS= 8'h18;
	localparam logic [7:0] MCM_PORT_REG_OFS= 8'h1C;
	// Control field positions
	localparam int MCM_CTRL_EN_BIT   = 0;
	localparam int MCM_CTRL_ACT_BIT  = 1;
	localparam int MCM_CTRL_RING_BIT = 2;
	localparam int MCM_CTRL_PLL_BIT  = 3;
	localparam int MCM_CTRL_LOW_BIT  = 4;
	// Status field positions
	localparam int MCM_STAT_DET_BIT  = 0;
	localparam int MCM_STAT_HALT_BIT = 1;
	localparam int MCM_STAT_RST_BIT  = 2;
	localparam int MCM_STAT_RING_BIT = 3;
	// Protect field positions
	localparam int MCM_PROT_CLK_BIT  = 0;
	localparam int MCM_PROT_MODE_BIT = 1;
	localparam int MCM_PROT_PORT_BIT = 2;
	// Interrupt status positions
	localparam int MCM_IRQ_STOP_BIT  = 0;
	localparam int MCM_IRQ_REOSC_BIT = 1;
	// Reset values
	localparam logic [4:0]  MCM_CTRL_RST = 5'h00;
	localparam logic [2:0]  MCM_PROT_RST = 3'h0;
	localparam logic [31:0] MCM_GRP_RST  = 32'h0000_0000;
	// Oscillator loss detection time
	localparam int MCM_LOSS_NS   = 2000;
	localparam int MCM_CLK_NS    = 8;
	localparam int MCM_LOSS_CYC  = MCM_LOSS_NS / MCM_CLK_NS;
	// AHB transfer codes
	localparam logic [1:0] MCM_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] MCM_HSIZE_WORD    = 3'h2;
	typedef enum logic [1:0] {MCM_RUN, MCM_STOPPED} mcm_osc_type;
endpackage

//--- core/mcm_osc_sense.sv
// Main oscillator presence detector.
// Assumes osc_toggle_in is a divided copy of the main oscillator, asynchronous.
`timescale 1ns/1ps
module mcm_osc_sense #(
	parameter int LOSS_CYC = 250
) (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic ce_in,
	input  wire logic osc_toggle_in,
	output logic      osc_alive_out
);
	logic        sync1_ff;
	logic        sync2_ff;
	logic        prev_ff;
	logic [15:0] cnt_ff;

	// Two-stage synchroniser and edge history
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			prev_ff  <= 1'b0;
		end else if (ce_in) begin
			sync1_ff <= osc_toggle_in;
			sync2_ff <= sync1_ff;
			prev_ff  <= sync2_ff;
		end
	end

	// Silence counter, restarted by each toggle
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_ff        <= 16'h0000;
			osc_alive_out <= 1'b1;
		end else if (ce_in) begin
			if (sync2_ff != prev_ff) begin
				cnt_ff        <= 16'h0000;
				osc_alive_out <= 1'b1;
			end else if (cnt_ff >= 16'(LOSS_CYC - 1)) begin
				osc_alive_out <= 1'b0;
			end else begin
				cnt_ff <= cnt_ff + 16'h0001;
			end
		end
	end
endmodule

//--- core/mcm_ahb_slave.sv
// AHB-Lite slave front end: latches the address phase, presents a
// one-cycle write or read strobe in the data phase, zero wait states.
// Assumes single word transfers from one master.
`timescale 1ns/1ps
module mcm_ahb_slave (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        ce_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic             wr_out,
	output logic             rd_out,
	output logic [7:0]       addr_out
);
	import mcm_pkg::*;
	logic       wr_ff;
	logic       rd_ff;
	logic [7:0] addr_ff;

	// Capture a valid address phase
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_ff   <= 1'b0;
			rd_ff   <= 1'b0;
			addr_ff <= 8'h00;
		end else if (ce_in) begin
			wr_ff <= hsel_in && hready_in && htrans_in[1] && hwrite_in;
			rd_ff <= hsel_in && hready_in && htrans_in[1] && !hwrite_in;
			if (hsel_in && hready_in && htrans_in[1]) begin
				addr_ff <= haddr_in[7:0];
			end
		end
	end

	// Always ready, always OKAY
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;
	assign wr_out        = wr_ff & ce_in;
	assign rd_out        = rd_ff & ce_in;
	assign addr_out      = addr_ff;
endmodule

//--- core/mcm_top.sv
// Main clock stop/re-oscillation monitor with protected register groups.
// Assumes AHB-Lite master at clk_in, oscillator toggle from the main clock.
//
// Register access over AHB-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module mcm_top #(
	parameter int LOSS_CYC = mcm_pkg::MCM_LOSS_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        ce_in,
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic             hreadyout_out,
	output logic             hresp_out,
	output logic [31:0]      hrdata_out,
	input  wire logic        osc_toggle_in,
	input  wire logic        ext_write_in,
	output logic             osc_reset_out,
	output logic             osc_halt_out,
	output logic             irq_out,
	output logic             ring_osc_on_out,
	output logic             cpu_on_ring_out,
	output logic             periph_on_ring_out,
	output logic [31:0]      clk_grp_out,
	output logic [31:0]      mode_grp_out,
	output logic [31:0]      port_grp_out
);
	import mcm_pkg::*;

	logic        wr;
	logic [7:0]  addr;
	logic        osc_alive;
	logic        ext_wr_s1_ff;
	logic        ext_wr_s2_ff;
	logic        osc_monitor_enable_ff;
	logic        monitor_action_select_ff;
	logic        ring_osc_cpu_select_ff;
	logic        pll_source_ff;
	logic        low_speed_ff;
	logic        clock_event_detected_flag_ff;
	logic        main_clock_halted_flag_ff;
	logic        halt_ff;
	logic        ring_on_ff;
	logic        clock_regs_unlock_ff;
	logic        mode_regs_unlock_ff;
	logic        port_regs_unlock_ff;
	logic [1:0]  irq_stat_ff;
	logic [1:0]  irq_mask_ff;
	logic [31:0] clk_grp_ff;
	logic [31:0] mode_grp_ff;
	logic [31:0] port_grp_ff;
	logic [31:0] hrdata_ff;
	mcm_osc_type osc_state_ff;
	logic        stop_evt;
	logic        reosc_evt;
	logic        evt_allowed;
	logic        irq_stop;
	logic        irq_reosc;
	logic        ext_wr;

	// Bus front end; reads are served from the address phase, so the read
	// strobe of the front end is not needed here
	mcm_ahb_slave u_bus (
		.clk_in        (clk_in),
		.srst_in       (srst_in),
		.ce_in         (ce_in),
		.hsel_in       (hsel_in),
		.haddr_in      (haddr_in),
		.htrans_in     (htrans_in),
		.hwrite_in     (hwrite_in),
		.hready_in     (hready_in),
		.hreadyout_out (hreadyout_out),
		.hresp_out     (hresp_out),
		.wr_out        (wr),
		.rd_out        (),
		.addr_out      (addr)
	);

	mcm_osc_sense #(.LOSS_CYC(LOSS_CYC)) u_sense (
		.clk_in        (clk_in),
		.srst_in       (srst_in),
		.ce_in         (ce_in),
		.osc_toggle_in (osc_toggle_in),
		.osc_alive_out (osc_alive)
	);

	// External write strobe from the rest of the chip, synchronised
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ext_wr_s1_ff <= 1'b0;
			ext_wr_s2_ff <= 1'b0;
		end else if (ce_in) begin
			ext_wr_s1_ff <= ext_write_in;
			ext_wr_s2_ff <= ext_wr_s1_ff;
		end
	end
	assign ext_wr = ext_wr_s2_ff & ce_in;

	// Oscillator state tracking. The state follows the sense output one cycle
	// late, so a difference between the two marks a stop or a re-oscillation.
	// It also runs while the monitor is off, so that enabling the monitor
	// never reports an edge that happened long before.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			osc_state_ff <= MCM_RUN;
		end else if (ce_in) begin
			case (osc_state_ff)
				MCM_RUN: begin
					if (!osc_alive) begin
						osc_state_ff <= MCM_STOPPED;
					end
				end
				MCM_STOPPED: begin
					if (osc_alive) begin
						osc_state_ff <= MCM_RUN;
					end
				end
				default: osc_state_ff <= MCM_RUN;
			endcase
		end
	end
	// Events only while enabled; the sense output already carries the loss delay
	assign stop_evt  = ce_in && osc_monitor_enable_ff
	                   && (osc_state_ff == MCM_RUN) && !osc_alive;
	assign reosc_evt = ce_in && osc_monitor_enable_ff
	                   && (osc_state_ff == MCM_STOPPED) && osc_alive;
	// Detect bit blocks further monitor interrupts until cleared
	assign evt_allowed = !clock_event_detected_flag_ff;
	assign irq_stop  = stop_evt && monitor_action_select_ff && evt_allowed;
	assign irq_reosc = reosc_evt && monitor_action_select_ff && evt_allowed;

	// Reset action: halt latched until hardware reset only. Re-oscillation
	// with the reset action halts as well, which is why software must never
	// arm that action while the clock is already stopped.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			halt_ff <= 1'b0;
		end else if (ce_in) begin
			if ((stop_evt || reosc_evt) && !monitor_action_select_ff) begin
				halt_ff <= 1'b1;
			end
		end
	end
	assign osc_reset_out = halt_ff;
	assign osc_halt_out  = halt_ff;

	// Control register: enable, action, ring select, source and speed flags.
	// A latched halt holds the register at its reset value, so the monitor
	// stays off until srst_in even if software keeps writing.
	always_ff @(posedge clk_in) begin
		if (srst_in || halt_ff) begin
			{low_speed_ff, pll_source_ff, ring_osc_cpu_select_ff,
			 monitor_action_select_ff, osc_monitor_enable_ff} <= MCM_CTRL_RST;
		end else if (ce_in) begin
			if (wr && addr == MCM_CTRL_OFS && clock_regs_unlock_ff) begin
				osc_monitor_enable_ff    <= hwdata_in[MCM_CTRL_EN_BIT];
				monitor_action_select_ff <= hwdata_in[MCM_CTRL_ACT_BIT];
				ring_osc_cpu_select_ff   <= hwdata_in[MCM_CTRL_RING_BIT];
				pll_source_ff            <= hwdata_in[MCM_CTRL_PLL_BIT];
				low_speed_ff             <= hwdata_in[MCM_CTRL_LOW_BIT];
			end
			// Hardware ring select wins over a same-cycle write
			if (irq_stop && !pll_source_ff && !low_speed_ff) begin
				ring_osc_cpu_select_ff <= 1'b1;
			end
		end
	end

	// Detect and halted flags; hardware set wins over software clear
	always_ff @(posedge clk_in) begin
		if (srst_in || halt_ff) begin
			clock_event_detected_flag_ff <= 1'b0;
			main_clock_halted_flag_ff    <= 1'b0;
		end else if (ce_in) begin
			if (wr && addr == MCM_STAT_OFS && clock_regs_unlock_ff
			    && !hwdata_in[MCM_STAT_DET_BIT]) begin
				clock_event_detected_flag_ff <= 1'b0;
			end
			if (irq_stop || irq_reosc) begin
				clock_event_detected_flag_ff <= 1'b1;
			end
			if (irq_stop) begin
				main_clock_halted_flag_ff <= 1'b1;
			end else if (irq_reosc) begin
				main_clock_halted_flag_ff <= 1'b0;
			end
		end
	end

	// Ring oscillator start on a stop interrupt unless pll_source_ff is set; runs until software leaves it
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ring_on_ff <= 1'b0;
		end else if (ce_in) begin
			if (irq_stop && !pll_source_ff) begin
				ring_on_ff <= 1'b1;
			end else if (wr && addr == MCM_CTRL_OFS && clock_regs_unlock_ff
			             && !hwdata_in[MCM_CTRL_RING_BIT] && !main_clock_halted_flag_ff) begin
				ring_on_ff <= 1'b0;
			end
		end
	end
	assign ring_osc_on_out    = ring_on_ff;
	assign cpu_on_ring_out    = ring_osc_cpu_select_ff && !low_speed_ff;
	assign periph_on_ring_out = ring_osc_cpu_select_ff || (ring_on_ff && low_speed_ff);

	// Protect register; port unlock self-clears on the next write anywhere.
	// Writes elsewhere in the chip arrive on ext_write_in two cycles late,
	// so the port write must follow the unlock at once to be sure of it.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			{port_regs_unlock_ff, mode_regs_unlock_ff, clock_regs_unlock_ff} <=
				MCM_PROT_RST;
		end else if (ce_in) begin
			if (wr && addr == MCM_PROT_OFS) begin
				clock_regs_unlock_ff <= hwdata_in[MCM_PROT_CLK_BIT];
				mode_regs_unlock_ff  <= hwdata_in[MCM_PROT_MODE_BIT];
				port_regs_unlock_ff  <= hwdata_in[MCM_PROT_PORT_BIT];
			end else if (wr || ext_wr) begin
				port_regs_unlock_ff <= 1'b0;
			end
		end
	end

	// Protected register groups
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			clk_grp_ff  <= MCM_GRP_RST;
			mode_grp_ff <= MCM_GRP_RST;
			port_grp_ff <= MCM_GRP_RST;
		end else if (ce_in && wr) begin
			if (addr == MCM_CLK_REG_OFS && clock_regs_unlock_ff) begin
				clk_grp_ff <= hwdata_in;
			end else if (addr == MCM_MODE_REG_OFS && mode_regs_unlock_ff) begin
				mode_grp_ff <= hwdata_in;
			end else if (addr == MCM_PORT_REG_OFS && port_regs_unlock_ff) begin
				port_grp_ff <= hwdata_in;
			end
		end
	end
	assign clk_grp_out  = clk_grp_ff;
	assign mode_grp_out = mode_grp_ff;
	assign port_grp_out = port_grp_ff;

	// Interrupt status (write one to clear, set wins) and mask.
	// An event in the same cycle as its clear stays pending, so none is lost.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			irq_stat_ff <= 2'h0;
			irq_mask_ff <= 2'h0;
		end else if (ce_in) begin
			if (wr && addr == MCM_IRQ_MSK_OFS) begin
				irq_mask_ff <= hwdata_in[1:0];
			end
			irq_stat_ff <= (irq_stat_ff & ~((wr && addr == MCM_IRQ_ST_OFS) ?
			                hwdata_in[1:0] : 2'h0)) | {irq_reosc, irq_stop};
		end
	end
	assign irq_out = |(irq_stat_ff & irq_mask_ff);

	// Read data mux, registered; unmapped reads return zero.
	// The word is chosen in the address phase so that it stands in the
	// data phase with no wait state; it returns to zero the cycle after.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (ce_in) begin
			hrdata_ff <= 32'h0000_0000;
			if (hsel_in && hready_in && htrans_in[1] && !hwrite_in) begin
				if (haddr_in[7:0] == MCM_CTRL_OFS) begin
					hrdata_ff <= {27'h0, low_speed_ff, pll_source_ff, ring_osc_cpu_select_ff,
					              monitor_action_select_ff, osc_monitor_enable_ff};
				end else if (haddr_in[7:0] == MCM_STAT_OFS) begin
					hrdata_ff <= {28'h0, ring_on_ff, halt_ff, main_clock_halted_flag_ff,
					              clock_event_detected_flag_ff};
				end else if (haddr_in[7:0] == MCM_PROT_OFS) begin
					hrdata_ff <= {29'h0, port_regs_unlock_ff, mode_regs_unlock_ff,
					              clock_regs_unlock_ff};
				end else if (haddr_in[7:0] == MCM_IRQ_ST_OFS) begin
					hrdata_ff <= {30'h0, irq_stat_ff};
				end else if (haddr_in[7:0] == MCM_IRQ_MSK_OFS) begin
					hrdata_ff <= {30'h0, irq_mask_ff};
				end else if (haddr_in[7:0] == MCM_CLK_REG_OFS) begin
					hrdata_ff <= clk_grp_ff;
				end else if (haddr_in[7:0] == MCM_MODE_REG_OFS) begin
					hrdata_ff <= mode_grp_ff;
				end else if (haddr_in[7:0] == MCM_PORT_REG_OFS) begin
					hrdata_ff <= port_grp_ff;
				end
			end
		end
	end
	assign hrdata_out = hrdata_ff;
endmodule

//--- bench/mcm_top_chk.sv
// Port checker for the clock monitor with write-protected groups.
// Assumes it is bound into mcm_top and shares its single clock.
`timescale 1ns/1ps
module mcm_top_chk import mcm_pkg::*; #(
	parameter int LOSS_CYC = MCM_LOSS_CYC
) (
	input wire logic        clk_in,
	input wire logic        srst_in,
	input wire logic        ce_in,
	input wire logic        hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0]  htrans_in,
	input wire logic        hwrite_in,
	input wire logic [31:0] hwdata_in,
	input wire logic        hready_in,
	input wire logic        hreadyout_out,
	input wire logic        hresp_out,
	input wire logic        osc_toggle_in,
	input wire logic        osc_reset_out,
	input wire logic        osc_halt_out,
	input wire logic        irq_out,
	input wire logic [31:0] clk_grp_out,
	input wire logic [31:0] mode_grp_out,
	input wire logic [31:0] port_grp_out
);
	logic        dph_ff;
	logic        dwr_ff;
	logic [7:0]  dad_ff;
	logic [1:0]  prot_ff;
	logic        port_ok_ff;
	logic        prev_ff;
	logic [15:0] quiet_ff;
	wire         wr_dp = dph_ff && dwr_ff;
	wire         clk_ok = wr_dp && dad_ff == MCM_CLK_REG_OFS && prot_ff[0];
	wire         mode_ok = wr_dp && dad_ff == MCM_MODE_REG_OFS && prot_ff[1];
	wire         port_ok = wr_dp && dad_ff == MCM_PORT_REG_OFS && port_ok_ff;

	// Shadow of the data phase and of the unlock state written by software
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			dph_ff <= 1'b0;
			prot_ff <= 2'h0;
			port_ok_ff <= 1'b0;
		end else if (ce_in) begin
			dph_ff <= hsel_in && hready_in && htrans_in[1];
			dwr_ff <= hwrite_in;
			dad_ff <= haddr_in[7:0];
			if (wr_dp && dad_ff == MCM_PROT_OFS)
				prot_ff <= hwdata_in[1:0];
			if (wr_dp)
				port_ok_ff <= dad_ff == MCM_PROT_OFS && hwdata_in[2];
		end
	end

	// Cycles since the oscillator copy last moved
	always_ff @(posedge clk_in) begin
		prev_ff <= osc_toggle_in;
		if (srst_in || osc_toggle_in != prev_ff)
			quiet_ff <= 16'h0;
		else if (quiet_ff != 16'hFFFF)
			quiet_ff <= quiet_ff + 16'h1;
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);

	// Bus answers, latched halt and group updates
	a_bus_okay: assert property (hreadyout_out && !hresp_out)
		else $error("bus answer not ready and okay");
	a_halt_held: assert property (osc_halt_out |=> osc_halt_out)
		else $error("halt released without reset");
	a_reset_halt: assert property (osc_reset_out |-> osc_halt_out)
		else $error("stop reset without halt");
	a_halt_quiet: assert property ($rose(osc_halt_out) |-> quiet_ff >= LOSS_CYC)
		else $error("halt without a stopped clock");
	a_clk_grp: assert property ($changed(clk_grp_out) |-> $past(clk_ok))
		else $error("clock group changed while locked");
	a_mode_grp: assert property ($changed(mode_grp_out) |-> $past(mode_ok))
		else $error("mode group changed while locked");
	a_port_grp: assert property ($changed(port_grp_out) |-> $past(port_ok))
		else $error("port group changed without fresh unlock");
	a_irq_held: assert property (irq_out && !wr_dp |=> irq_out || osc_halt_out)
		else $error("irq dropped without a write");
	a_reset_clear: assert property (disable iff (1'b0) srst_in |=> !osc_halt_out
		&& !irq_out && clk_grp_out == MCM_GRP_RST && port_grp_out == MCM_GRP_RST)
		else $error("state not cleared by reset");

	c_irq: cover property ($rose(irq_out));
	c_halt: cover property ($rose(osc_halt_out));
	c_port: cover property ($changed(port_grp_out));
endmodule

bind mcm_top mcm_top_chk #(.LOSS_CYC(LOSS_CYC)) u_chk (
	.clk_in, .srst_in, .ce_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in,
	.hwdata_in, .hready_in, .hreadyout_out, .hresp_out, .osc_toggle_in,
	.osc_reset_out, .osc_halt_out, .irq_out, .clk_grp_out, .mode_grp_out,
	.port_grp_out
);

//--- bench/test_main_clock_stop_monitor_protect.sv
// Self-checking bench for the clock monitor and write protection.
// Assumes mcm_top with a shortened loss time and a 125 MHz clock.
`timescale 1ns/1ps
module test_main_clock_stop_monitor_protect;
	import mcm_pkg::*;
	localparam int LOSS = 8;
	localparam int WT = LOSS + 24;
	logic        clk_in, srst_in, hsel, hwrite, osc, osc_run, ext_wr, hready;
	logic        osc_rst, osc_halt, irq, ring_on, cpu_ring, per_ring, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, clk_grp, mode_grp, port_grp;
	logic [31:0] ge[3];
	logic [7:0]  go[3] = '{MCM_CLK_REG_OFS, MCM_MODE_REG_OFS, MCM_PORT_REG_OFS};
	logic [4:0]  cfg[3] = '{5'h0B, 5'h13, 5'h03};
	logic [31:0] cex[3] = '{32'h0B, 32'h13, 32'h07};
	logic [31:0] cmk[3] = '{32'h1F, 32'h1B, 32'h1F};
	logic [31:0] oex[3] = '{32'h0, 32'h5, 32'h7};
	logic [31:0] omk[3] = '{32'h2, 32'h7, 32'h7};
	wire  [31:0] route = {29'h0, ring_on, cpu_ring, per_ring};
	wire  [31:0] irq_w = {31'h0, irq};
	wire  [31:0] halt_w = {30'h0, osc_rst, osc_halt};
	int          errors, num_checks;

	mcm_top #(.LOSS_CYC(LOSS)) uut (
		.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1), .hsel_in(hsel),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(MCM_HSIZE_WORD), .hwdata_in(hwdata), .hready_in(hready),
		.hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
		.osc_toggle_in(osc), .ext_write_in(ext_wr), .osc_reset_out(osc_rst),
		.osc_halt_out(osc_halt), .irq_out(irq), .ring_osc_on_out(ring_on),
		.cpu_on_ring_out(cpu_ring), .periph_on_ring_out(per_ring),
		.clk_grp_out(clk_grp), .mode_grp_out(mode_grp), .port_grp_out(port_grp)
	);

	// Clock and main oscillator stand-in; the copy toggles every cycle, far
	// above the slowest clock that the monitor can watch
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
		if (osc_run)
			osc <= ~osc;

	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		num_checks++;
		if (got !== ex) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// One single AHB-Lite word transfer, address then data phase
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_in);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= MCM_HTRANS_NONSEQ;
		hwrite <= w;
		do @(posedge clk_in); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, a, d, r);
	endtask
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] ex,
		input logic [31:0] m = 32'hFFFF_FFFF);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, r);
		chk(nm, ex & m, r & m);
	endtask
	task automatic do_reset();
		@(posedge clk_in);
		srst_in <= 1'b1;
		osc_run <= 1'b1;
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
	endtask
	// Oscillator loss stands for an outside failure; a planned stop would clear
	// the monitor enable first and wait mode is never entered
	task automatic osc_set(input logic on);
		osc_run <= on;
		repeat (WT) @(posedge clk_in);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog against a hung transfer
	initial begin
		#200000;
		errors++;
		tally_and_finish();
	end

	initial begin
		srst_in = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		osc = 1'b0;
		osc_run = 1'b1;
		ext_wr = 1'b0;
		errors = 0;
		num_checks = 0;
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		// Locked after reset, then each unlock bit opens only its group
		rd("protect", MCM_PROT_OFS, 32'h0);
		for (int i = 0; i < 3; i++) begin
			ge[i] = 32'h0;
			wr(go[i], 32'hFFFF_FFFF);
			rd("locked group", go[i], 32'h0);
		end
		for (int i = 0; i < 3; i++) begin
			wr(MCM_PROT_OFS, 32'h1 << i);
			ge[i] = 32'h1234_5670 + i;
			wr(go[i], ge[i]);
			for (int j = 0; j < 3; j++)
				if (j != i)
					wr(go[j], 32'hFFFF_FFFF);
			for (int j = 0; j < 3; j++)
				rd("group", go[j], ge[j]);
			rd("protect", MCM_PROT_OFS, i == 2 ? 32'h0 : (32'h1 << i));
			wr(MCM_PROT_OFS, 32'h0);
		end
		// Port unlock consumed by an unrelated bus write or outside write
		for (int k = 0; k < 2; k++) begin
			wr(MCM_PROT_OFS, 32'h4);
			if (k == 0)
				wr(MCM_IRQ_MSK_OFS, 32'h0);
			else begin
				@(posedge clk_in);
				ext_wr <= 1'b1;
				repeat (2) @(posedge clk_in);
				ext_wr <= 1'b0;
				repeat (4) @(posedge clk_in);
			end
			wr(MCM_PORT_REG_OFS, 32'hFFFF_FFFF);
			rd("port group", MCM_PORT_REG_OFS, ge[2]);
		end
		// Group outputs and the bus response seen on the pins
		chk("clock group pins", ge[0], clk_grp);
		chk("mode group pins", ge[1], mode_grp);
		chk("port group pins", ge[2], port_grp);
		chk("bus response", 32'h0, {31'h0, hresp});
		rd("unmapped", 8'h40, 32'h0);
		$display("test protect done");
		// Interrupt action for PLL, low-speed and main clock sources
		for (int i = 0; i < 3; i++) begin
			do_reset();
			wr(MCM_PROT_OFS, 32'h1);
			wr(MCM_CTRL_OFS, {27'h0, cfg[i]});
			osc_set(1'b0);
			chk("irq masked", 32'h0, irq_w);
			rd("stop flags", MCM_STAT_OFS, 32'h3, 32'h3);
			rd("irq status", MCM_IRQ_ST_OFS, 32'h1);
			rd("ctrl", MCM_CTRL_OFS, cex[i], cmk[i]);
			chk("clock routing", oex[i] & omk[i], route & omk[i]);
			wr(MCM_IRQ_MSK_OFS, 32'h3);
			@(posedge clk_in);
			chk("irq unmasked", 32'h1, irq_w);
		end
		$display("test stop interrupt done");
		// Raised flag blocks the next event; clearing it lets events through
		wr(MCM_IRQ_ST_OFS, 32'h1);
		@(posedge clk_in);
		chk("irq cleared", 32'h0, irq_w);
		osc_set(1'b1);
		rd("irq blocked", MCM_IRQ_ST_OFS, 32'h0);
		wr(MCM_STAT_OFS, 32'h0);
		osc_set(1'b0);
		rd("irq again", MCM_IRQ_ST_OFS, 32'h1);
		wr(MCM_IRQ_ST_OFS, 32'h1);
		wr(MCM_STAT_OFS, 32'h0);
		osc_set(1'b1);
		rd("reosc irq", MCM_IRQ_ST_OFS, 32'h2);
		rd("reosc flags", MCM_STAT_OFS, 32'h1, 32'h3);
		rd("ring kept", MCM_CTRL_OFS, 32'h7);
		chk("reosc irq line", 32'h1, irq_w);
		// Software moves the clocks back to the main clock
		wr(MCM_CTRL_OFS, 32'h3);
		@(posedge clk_in);
		chk("clock routing back", 32'h0, route);
		$display("test reoscillation done");
		// Reset action latches halt until a hardware reset
		do_reset();
		wr(MCM_PROT_OFS, 32'h1);
		wr(MCM_IRQ_MSK_OFS, 32'h3);
		// Reset action is armed only while the main clock runs
		wr(MCM_CTRL_OFS, 32'h1);
		osc_set(1'b0);
		chk("stop reset", 32'h3, halt_w);
		chk("no irq", 32'h0, irq_w);
		osc_set(1'b1);
		wr(MCM_CTRL_OFS, 32'h0);
		@(posedge clk_in);
		chk("halt held", 32'h3, halt_w);
		do_reset();
		@(posedge clk_in);
		chk("halt released", 32'h0, halt_w);
		$display("test stop reset done");
		tally_and_finish();
	end
endmodule
